// [hdl/adc_seq_pkg.sv]
// Constants, field positions and types for the converter sequencer
// Notes on behaviour
// - Fixed single: one conversion, own pair, interrupt
// - Fixed continuous: results rotate through eight pairs
// - Fixed continuous: interrupt every four or eight
// - Scan single: each selected channel once, own pair
// - Scan: interrupt at end, or after four too
// - Scan single with one channel equals fixed single
// - Scan continuous: restart first channel, rotate pairs
// - Dual: alternate two inputs, first in even pairs
// - Dual: interrupt every four or eight conversions
// - Single step: one channel per start, interrupt
// - Timer overflow starts; ignored while converting
// - Writing immediate start begins conversion at once
// - Pin edge starts; further edges ignored while busy
// - Limit compare, inside inclusive or outside selectable
// - Boundary enable cleared disables boundary interrupts
// - Outside mode: early four-MSB limit compare
// - Otherwise compare again at eight MSBs
// - Per-channel flag for boundary-causing channels
// - Clock divider ratios one to eight
// - Ten-bit conversion takes 4 us at 9 MHz
// - Runs in idle; completion interrupt wakes processor
// - No operation in power-down; disable saves power
package adc_seq_pkg;

  // Register byte addresses
  localparam logic [7:0] CTRL_ADDR  = 8'h00;
  localparam logic [7:0] CHAN_ADDR  = 8'h04;
  localparam logic [7:0] LIMIT_ADDR = 8'h08;
  localparam logic [7:0] STAT_ADDR  = 8'h0C;
  localparam logic [7:0] BFLAG_ADDR = 8'h10;
  localparam logic [2:0] RES_PAGE   = 3'h1;   // Result pairs at 0x20..0x3C

  // Control register fields
  localparam int CTRL_EN   = 0;
  localparam int CTRL_MODE = 1;    // 3 bits
  localparam int CTRL_SRC  = 4;    // 2 bits
  localparam int CTRL_CIE  = 6;
  localparam int CTRL_BIE  = 7;
  localparam int CTRL_BOUT = 8;
  localparam int CTRL_GRP4 = 9;
  localparam int CTRL_DIV  = 10;   // 3 bits, ratio is value plus one
  localparam int CTRL_W    = 13;

  // Channel register fields
  localparam int CHAN_SEL  = 0;    // 8 bits scan mask
  localparam int CHAN_FIX  = 8;    // 3 bits fixed or first dual input
  localparam int CHAN_SEC  = 12;   // 3 bits second dual input
  localparam int CHAN_W    = 15;

  // Limit register fields
  localparam int LIM_LO    = 0;
  localparam int LIM_HI    = 16;
  localparam logic [9:0] LIM_HI_RST = 10'h3FF;
  localparam logic [9:0] LIM_LO_RST = 10'h000;

  // Status register fields
  localparam int STAT_DONE = 0;
  localparam int STAT_BND  = 1;
  localparam int STAT_BUSY = 2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Conversion timing, in converter clock ticks
  localparam int SAR_BITS     = 10;
  localparam int CONV_TIME_NS = 4000;
  localparam int ADC_CLK_KHZ  = 9000;
  localparam int CONV_TICKS   = CONV_TIME_NS * ADC_CLK_KHZ / 1000000;
  localparam int SAMPLE_TICKS = CONV_TICKS - SAR_BITS;

  typedef enum logic [2:0] {
    MODE_FIX_SINGLE  = 3'h0,
    MODE_FIX_CONT    = 3'h1,
    MODE_SCAN_SINGLE = 3'h2,
    MODE_SCAN_CONT   = 3'h3,
    MODE_DUAL_CONT   = 3'h4,
    MODE_STEP        = 3'h5
  } mode_t;

  typedef enum logic [1:0] {
    SRC_TIMER = 2'h0,
    SRC_IMM   = 2'h1,
    SRC_EDGE  = 2'h2
  } src_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONV   = 3'b100
  } seq_state_t;

endpackage : adc_seq_pkg

// [hdl/sar_adc_sequencer.sv]
// Sequencer, result store and AXI4-Lite register file for the SAR converter
`timescale 1ns/1ns
module sar_adc_sequencer (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  input  wire logic        timer0_ovf,
  input  wire logic        edge_trigger_pin,
  input  wire logic        cpu_idle,
  input  wire logic        pwr_down,
  input  wire logic        cmp_in,
  output logic [2:0]       mux_ch,
  output logic             sample_hold,
  output logic [9:0]       dac_code,
  output logic             adc_power_en,
  output logic             conv_irq,
  output logic             bnd_irq,
  output logic             idle_wake
);

  // Whole module state, registered once per clock
  typedef struct packed {
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   aw_got;   // Address held, waiting for data
    logic                   w_got;    // Data held, waiting for address
    logic [7:0]             aw_addr;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   arready;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [31:0]            rdata;
    logic [12:0]            ctrl;     // Control register
    logic [14:0]            chan;     // Channel selection register
    logic [9:0]             lim_lo;
    logic [9:0]             lim_hi;
    logic                   done;     // Sticky completion flag
    logic                   bnd;      // Sticky boundary flag
    logic [7:0]             bflag;    // Per-channel boundary flags
    logic [7:0][9:0]        res;      // Eight result pairs
    adc_seq_pkg::seq_state_t st;
    logic                   running;  // Follow-on conversion without trigger
    logic [2:0]             ch;       // Channel being converted
    logic [2:0]             slot;     // Result pair to write
    logic [2:0]             cnt;      // Conversions in current group
    logic [7:0]             pend;     // Scan channels still to convert
    logic                   second;   // Dual mode: next is second input
    logic [2:0]             div_cnt;
    logic                   tick;     // Converter clock enable pulse
    logic [4:0]             phase;    // Sample phase counter
    logic [3:0]             bitpos;
    logic [9:0]             sar;      // Trial code driven to the DAC
    logic                   bnd_hit;  // Boundary already raised this conversion
    logic                   edge_prev;
    logic                   conv_irq;
    logic                   bnd_irq;
    logic                   wake;
    logic                   sample;
    logic                   pwr_en;
  } state_t;

  state_t q;
  state_t n;

  // Lowest set channel of a mask, used for scan start, reload and step
  function automatic logic [2:0] first_ch(input logic [7:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : first_ch

  // Byte-lane merge of a write into an old register word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Next-state logic: bus slave, then sequencer, so hardware sets win
  always_comb begin
    logic [31:0] wv;
    logic        imm_wr;
    logic        trig;
    logic        active;
    logic        irq_ev;
    logic        hit;
    logic [9:0]  d;
    logic [7:0]  left;
    logic [7:0]  sel;
    logic [7:0]  pmask;
    adc_seq_pkg::mode_t mode;
    wv     = 32'h0;
    imm_wr = 1'b0;
    trig   = 1'b0;
    irq_ev = 1'b0;
    hit    = 1'b0;
    d      = 10'h0;
    left   = 8'h0;
    pmask  = 8'h0;
    n      = q;

    // Write address and data are taken independently
    if (s_axi_awvalid && q.awready) begin
      n.aw_got  = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      n.w_got  = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    // Perform the write once both halves are held
    if (q.aw_got && q.w_got && !q.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = adc_seq_pkg::RESP_OKAY;
      unique case ({q.aw_addr[7:2], 2'b00})
        adc_seq_pkg::CTRL_ADDR: begin
          wv     = merge({19'h0, q.ctrl}, q.w_data, q.w_strb);
          n.ctrl = wv[12:0];
          // Programming the immediate mode starts a conversion
          imm_wr = (wv[adc_seq_pkg::CTRL_SRC +: 2] == adc_seq_pkg::SRC_IMM);
        end
        adc_seq_pkg::CHAN_ADDR: begin
          wv     = merge({17'h0, q.chan}, q.w_data, q.w_strb);
          n.chan = wv[14:0];
        end
        adc_seq_pkg::LIMIT_ADDR: begin
          wv       = merge({6'h0, q.lim_hi, 6'h0, q.lim_lo}, q.w_data, q.w_strb);
          n.lim_lo = wv[adc_seq_pkg::LIM_LO +: 10];
          n.lim_hi = wv[adc_seq_pkg::LIM_HI +: 10];
        end
        adc_seq_pkg::STAT_ADDR: begin
          // Write one to clear; a same-cycle event below sets again
          if (q.w_strb[0] && q.w_data[adc_seq_pkg::STAT_DONE]) begin
            n.done = 1'b0;
          end
          if (q.w_strb[0] && q.w_data[adc_seq_pkg::STAT_BND]) begin
            n.bnd = 1'b0;
          end
        end
        adc_seq_pkg::BFLAG_ADDR: begin
          if (q.w_strb[0]) begin
            n.bflag = q.bflag & ~q.w_data[7:0];
          end
        end
        default: begin
          // Result pairs are read-only; other addresses are unmapped
          if (q.aw_addr[7:5] != adc_seq_pkg::RES_PAGE) begin
            n.bresp = adc_seq_pkg::RESP_SLVERR;
          end
        end
      endcase
    end

    // Read channel: one outstanding read, data latched at acceptance
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = adc_seq_pkg::RESP_OKAY;
      n.rdata  = 32'h0;
      unique case ({s_axi_araddr[7:2], 2'b00})
        adc_seq_pkg::CTRL_ADDR:  n.rdata = {19'h0, q.ctrl};
        adc_seq_pkg::CHAN_ADDR:  n.rdata = {17'h0, q.chan};
        adc_seq_pkg::LIMIT_ADDR: n.rdata = {6'h0, q.lim_hi, 6'h0, q.lim_lo};
        adc_seq_pkg::STAT_ADDR:  n.rdata = {29'h0, q.st != adc_seq_pkg::ST_IDLE, q.bnd, q.done};
        adc_seq_pkg::BFLAG_ADDR: n.rdata = {24'h0, q.bflag};
        default: begin
          if (s_axi_araddr[7:5] == adc_seq_pkg::RES_PAGE) begin
            // Left byte holds the two top bits, right byte the low eight
            n.rdata = {16'h0, 6'h0, q.res[s_axi_araddr[4:2]][9:8],
                       q.res[s_axi_araddr[4:2]][7:0]};
          end else begin
            n.rresp = adc_seq_pkg::RESP_SLVERR;
          end
        end
      endcase
    end

    // Converter clock divider, ratio one to eight
    n.tick    = 1'b0;
    n.div_cnt = q.div_cnt + 3'h1;
    if (q.div_cnt >= q.ctrl[adc_seq_pkg::CTRL_DIV +: 3]) begin
      n.div_cnt = 3'h0;
      n.tick    = 1'b1;
    end

    // Start source selection; triggers only count while idle
    // Control seen as just written, so an immediate start in the enabling write counts
    mode   = adc_seq_pkg::mode_t'(n.ctrl[adc_seq_pkg::CTRL_MODE +: 3]);
    sel    = q.chan[adc_seq_pkg::CHAN_SEL +: 8];
    active = n.ctrl[adc_seq_pkg::CTRL_EN] && !pwr_down;
    n.edge_prev = edge_trigger_pin;
    unique case (n.ctrl[adc_seq_pkg::CTRL_SRC +: 2])
      adc_seq_pkg::SRC_TIMER: trig = timer0_ovf;
      adc_seq_pkg::SRC_EDGE:  trig = edge_trigger_pin ^ q.edge_prev;
      default:                trig = imm_wr;
    endcase

    unique case (q.st)
      adc_seq_pkg::ST_IDLE: begin
        if (active && q.running) begin
          n.st = adc_seq_pkg::ST_SAMPLE;
        end else if (active && trig) begin
          n.st = adc_seq_pkg::ST_SAMPLE;
          n.cnt    = 3'h0;
          n.second = 1'b0;
          unique case (mode)
            adc_seq_pkg::MODE_FIX_CONT, adc_seq_pkg::MODE_DUAL_CONT: begin
              n.ch      = q.chan[adc_seq_pkg::CHAN_FIX +: 3];
              n.slot    = 3'h0;
              n.second  = 1'b1;
              n.running = 1'b1;
            end
            adc_seq_pkg::MODE_SCAN_SINGLE, adc_seq_pkg::MODE_SCAN_CONT: begin
              n.pend    = sel;
              n.ch      = first_ch(sel);
              n.slot    = (mode == adc_seq_pkg::MODE_SCAN_CONT) ? 3'h0 : first_ch(sel);
              n.running = 1'b1;
              if (sel == 8'h0) begin
                n.st      = adc_seq_pkg::ST_IDLE;
                n.running = 1'b0;
              end
            end
            adc_seq_pkg::MODE_STEP: begin
              // Resume the scan where the last step left it
              pmask  = (q.pend == 8'h0) ? sel : q.pend;
              n.pend = pmask;
              n.ch   = first_ch(pmask);
              n.slot = first_ch(pmask);
              if (pmask == 8'h0) begin
                n.st = adc_seq_pkg::ST_IDLE;
              end
            end
            default: begin
              n.ch   = q.chan[adc_seq_pkg::CHAN_FIX +: 3];
              n.slot = q.chan[adc_seq_pkg::CHAN_FIX +: 3];
            end
          endcase
        end
        n.phase   = 5'h0;
        n.bitpos  = 4'(adc_seq_pkg::SAR_BITS - 1);
        n.sar     = 10'h200;
        n.bnd_hit = 1'b0;
      end
      adc_seq_pkg::ST_SAMPLE: begin
        if (q.tick) begin
          n.phase = q.phase + 5'h1;
          if (q.phase == 5'(adc_seq_pkg::SAMPLE_TICKS - 1)) begin
            n.st = adc_seq_pkg::ST_CONV;
          end
        end
      end
      adc_seq_pkg::ST_CONV: begin
        if (q.tick) begin
          // Decide the current bit and try the next one down
          d = q.sar;
          if (!cmp_in) begin
            d[q.bitpos] = 1'b0;
          end
          n.sar = d;
          if (q.bitpos != 4'h0) begin
            n.sar[q.bitpos - 4'h1] = 1'b1;
          end
          n.bitpos = q.bitpos - 4'h1;
          // Early outside-limit checks on partial results
          if (q.ctrl[adc_seq_pkg::CTRL_BOUT] && !q.bnd_hit) begin
            if (q.bitpos == 4'h6) begin
              hit = (d[9:6] > q.lim_hi[9:6]) || (d[9:6] < q.lim_lo[9:6]);
            end else if (q.bitpos == 4'h2) begin
              hit = (d[9:2] > q.lim_hi[9:2]) || (d[9:2] < q.lim_lo[9:2]);
            end
          end
          if (q.bitpos == 4'h0) begin
            n.st          = adc_seq_pkg::ST_IDLE;
            n.res[q.slot] = d;
            n.cnt         = q.cnt + 3'h1;
            n.slot        = q.slot + 3'h1;
            left          = q.pend & ~(8'h1 << q.ch);
            if (q.ctrl[adc_seq_pkg::CTRL_BOUT]) begin
              hit = hit || (!q.bnd_hit && ((d > q.lim_hi) || (d < q.lim_lo)));
            end else begin
              hit = (d >= q.lim_lo) && (d <= q.lim_hi);
            end
            unique case (mode)
              adc_seq_pkg::MODE_FIX_CONT, adc_seq_pkg::MODE_DUAL_CONT: begin
                irq_ev = q.ctrl[adc_seq_pkg::CTRL_GRP4] ? (q.cnt[1:0] == 2'h3)
                                                       : (q.cnt == 3'h7);
                if (mode == adc_seq_pkg::MODE_DUAL_CONT) begin
                  n.second = !q.second;
                  n.ch     = q.second ? q.chan[adc_seq_pkg::CHAN_SEC +: 3]
                                      : q.chan[adc_seq_pkg::CHAN_FIX +: 3];
                end
              end
              adc_seq_pkg::MODE_SCAN_SINGLE, adc_seq_pkg::MODE_SCAN_CONT: begin
                irq_ev = (left == 8'h0) ||
                         (q.ctrl[adc_seq_pkg::CTRL_GRP4] && q.cnt == 3'h3);
                n.pend = left;
                n.ch   = first_ch(left);
                if (mode == adc_seq_pkg::MODE_SCAN_SINGLE) begin
                  n.slot = first_ch(left);
                end
                if (left == 8'h0) begin
                  n.cnt     = 3'h0;
                  n.pend    = sel;
                  n.ch      = first_ch(sel);
                  n.running = (mode == adc_seq_pkg::MODE_SCAN_CONT) && (sel != 8'h0);
                end
              end
              adc_seq_pkg::MODE_STEP: begin
                irq_ev    = 1'b1;
                n.pend    = left;
                n.running = 1'b0;
              end
              default: begin
                irq_ev    = 1'b1;
                n.running = 1'b0;
              end
            endcase
          end
        end
      end
      default: begin
        n.st = adc_seq_pkg::ST_IDLE;
      end
    endcase

    // Boundary events need their enable; they also mark the channel
    if (hit && q.ctrl[adc_seq_pkg::CTRL_BIE]) begin
      n.bnd_hit     = 1'b1;
      n.bnd         = 1'b1;
      n.bflag[q.ch] = 1'b1;
    end
    if (irq_ev) begin
      n.done = 1'b1;
    end

    // Disable or power-down aborts any conversion in flight
    if (!active) begin
      n.st      = adc_seq_pkg::ST_IDLE;
      n.running = 1'b0;
    end

    // Registered outputs
    n.awready  = !n.aw_got && !n.bvalid;
    n.wready   = !n.w_got && !n.bvalid;
    n.arready  = !n.rvalid;
    n.conv_irq = n.done && n.ctrl[adc_seq_pkg::CTRL_CIE];
    n.bnd_irq  = n.bnd && n.ctrl[adc_seq_pkg::CTRL_BIE];
    n.wake     = n.conv_irq && cpu_idle;
    n.sample   = (n.st == adc_seq_pkg::ST_SAMPLE);
    n.pwr_en   = active;
  end

  // State register, synchronous active-low reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q        <= '0;
      q.st     <= adc_seq_pkg::ST_IDLE;
      q.lim_hi <= adc_seq_pkg::LIM_HI_RST;
      q.lim_lo <= adc_seq_pkg::LIM_LO_RST;
    end else begin
      q <= n;
    end
  end

  // Ports straight from the state register
  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign mux_ch        = q.ch;
  assign sample_hold   = q.sample;
  assign dac_code      = q.sar;
  assign adc_power_en  = q.pwr_en;
  assign conv_irq      = q.conv_irq;
  assign bnd_irq       = q.bnd_irq;
  assign idle_wake     = q.wake;

endmodule : sar_adc_sequencer

// [tb/adc_seq_sva.sv]
// Port-level checks on the converter sequencer
`timescale 1ns/1ns
module adc_seq_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        pwr_down,
  input wire logic [2:0]  mux_ch,
  input wire logic        sample_hold,
  input wire logic [9:0]  dac_code,
  input wire logic        adc_power_en,
  input wire logic        conv_irq,
  input wire logic        idle_wake
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both halves of a write taken at one edge
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Held sample phase, second cycle onward
  sequence s_holding;
    sample_hold && $past(sample_hold);
  endsequence
  pwr_off_a: assert property (pwr_down |=> !adc_power_en && !sample_hold)
    else $error("converter active in power-down");
  sample_dac_a: assert property (sample_hold |-> dac_code == 10'h200)
    else $error("trial code not at midscale while sampling");
  mux_steady_a: assert property (s_holding |-> $stable(mux_ch))
    else $error("channel moved during sampling");
  wake_cause_a: assert property (idle_wake |-> conv_irq || $past(conv_irq))
    else $error("wake without conversion interrupt");
  wr_answer_a: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address accepted with read pending");
endmodule : adc_seq_sva

bind sar_adc_sequencer adc_seq_sva u_sva (.*);

// [tb/analog_side.sv]
// Behavioural analog front end: mux, sample-hold and comparator
`timescale 1ns/1ns
module analog_side (
  input  wire logic       aclk,
  input  wire logic [2:0] mux_ch,
  input  wire logic       sample_hold,
  input  wire logic [9:0] dac_code,
  output logic            cmp_in
);
  logic [9:0] held = 10'h155;  // Level on the hold capacitor
  // Each channel carries its number in the top bits; tracked only while sampling
  always_ff @(posedge aclk) begin
    if (sample_hold) begin
      held <= {mux_ch, 7'h15};
    end
  end
  // Comparator high while the held level is at or above the trial code
  assign cmp_in = (held >= dac_code);
endmodule : analog_side

// [tb/sar_adc_sequencer_tb.sv]
// Self-checking bench for the converter sequencer
`timescale 1ns/1ns
module sar_adc_sequencer_tb;
  logic        aclk = 1'b0, aresetn = 1'b0, timer0_ovf = 1'b0, edge_trigger_pin = 1'b0;
  logic        cpu_idle = 1'b0, pwr_down = 1'b0, s_axi_bready = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;  // Full words only
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        cmp_in, sample_hold, adc_power_en, conv_irq, bnd_irq, idle_wake;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rdv;
  logic [2:0]  mux_ch;
  logic [9:0]  dac_code;
  int          failures = 0, n_checks = 0;

  sar_adc_sequencer dut (.*);
  analog_side u_analog (.aclk, .mux_ch, .sample_hold, .dac_code, .cmp_in);

  // Clock at 4 ns period
  initial forever #2 aclk = ~aclk;
  // Expected level of a channel, mirrors the front-end stimulus
  function automatic logic [31:0] lvl(input logic [2:0] c);
    return {22'h0, c, 7'h15};
  endfunction : lvl
  // Control word: enable, mode, source, {group4, outside, bnd en, conv en}
  function automatic logic [31:0] ctl(input logic [2:0] m, input logic [1:0] s,
                                      input logic [3:0] f);
    return 32'h1 | (32'(m) << adc_seq_pkg::CTRL_MODE) | (32'(s) << adc_seq_pkg::CTRL_SRC)
           | (32'(f) << adc_seq_pkg::CTRL_CIE);
  endfunction : ctl
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Write: offer both halves, drop each when taken, wait for the response
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    rdv = s_axi_rdata;
    rs  = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // Bounded wait for an interrupt line (0 conversion, 1 boundary)
  task wait_on(input logic which);
    int i;
    i = 0;
    while ((which ? bnd_irq : conv_irq) !== 1'b1 && i < 3000) begin
      @(posedge aclk);
      i++;
    end
  endtask : wait_on
  // Disable and clear all sticky status; a running conversion is abandoned
  task stop();
    wr(adc_seq_pkg::CTRL_ADDR, 32'h0);
    wr(adc_seq_pkg::STAT_ADDR, 32'h3);
    wr(adc_seq_pkg::BFLAG_ADDR, 32'hFF);
  endtask : stop

  task t_reset();
    rd(adc_seq_pkg::LIMIT_ADDR);
    chk("limits", 32'h03FF0000, rdv);
    rd(8'hFC);
    chk("unmapped", 32'(adc_seq_pkg::RESP_SLVERR), 32'(rs));
  endtask : t_reset
  task t_fix();
    cpu_idle <= 1'b1;
    wr(adc_seq_pkg::CHAN_ADDR, 32'h0300);
    wr(adc_seq_pkg::CTRL_ADDR, ctl(adc_seq_pkg::MODE_FIX_SINGLE, adc_seq_pkg::SRC_IMM, 4'h1));
    wait_on(1'b0);
    chk("conv_irq", 32'h1, 32'(conv_irq));
    repeat (2) @(posedge aclk);
    chk("idle_wake", 32'h1, 32'(idle_wake));
    rd(8'h2C);
    chk("pair3", lvl(3), rdv);
    rd(8'h20);
    chk("pair0", 32'h0, rdv);
    wr(adc_seq_pkg::STAT_ADDR, 32'h1);
    repeat (2) @(posedge aclk);
    chk("conv_irq", 32'h0, 32'(conv_irq));
    cpu_idle <= 1'b0;
    stop();
  endtask : t_fix
  task t_dual();
    wr(adc_seq_pkg::CHAN_ADDR, 32'h6100);
    wr(adc_seq_pkg::CTRL_ADDR, ctl(adc_seq_pkg::MODE_DUAL_CONT, adc_seq_pkg::SRC_IMM, 4'h9));
    wait_on(1'b0);
    stop();
    for (int k = 0; k < 5; k++) begin
      rd(8'h20 + 8'(4 * k));
      chk("dual", k == 4 ? 32'h0 : lvl(k[0] ? 3'h6 : 3'h1), rdv);
    end
  endtask : t_dual
  task t_scan();
    wr(adc_seq_pkg::CHAN_ADDR, 32'h0025);
    wr(adc_seq_pkg::CTRL_ADDR, ctl(adc_seq_pkg::MODE_SCAN_SINGLE, adc_seq_pkg::SRC_TIMER, 4'h1));
    // Second overflow lands inside the first conversion and must be dropped
    for (int p = 0; p < 2; p++) begin
      timer0_ovf <= 1'b1;
      @(posedge aclk);
      timer0_ovf <= 1'b0;
      repeat (20) @(posedge aclk);
    end
    wait_on(1'b0);
    chk("scan irq", 32'h1, 32'(conv_irq));
    for (int k = 0; k < 8; k++) begin
      rd(8'h20 + 8'(4 * k));
      chk("pair", k inside {0, 2, 5} ? lvl(3'(k)) : k inside {1, 3} ? lvl(3'h6) : 0, rdv);
    end
    chk("pair7 kept", 32'h0, rdv);
    wr(adc_seq_pkg::STAT_ADDR, 32'h1);
    repeat (300) @(posedge aclk);
    chk("no restart", 32'h0, 32'(conv_irq));
    stop();
  endtask : t_scan
  task t_bound();
    wr(adc_seq_pkg::LIMIT_ADDR, 32'h02000100);
    wr(adc_seq_pkg::CHAN_ADDR, 32'h0700);
    wr(adc_seq_pkg::CTRL_ADDR, ctl(adc_seq_pkg::MODE_FIX_SINGLE, adc_seq_pkg::SRC_EDGE, 4'h6));
    edge_trigger_pin <= 1'b1;
    wait_on(1'b1);
    chk("bnd_irq", 32'h1, 32'(bnd_irq));
    rd(adc_seq_pkg::BFLAG_ADDR);
    chk("bnd flags", 32'h80, rdv);
    stop();
    wr(adc_seq_pkg::CTRL_ADDR, ctl(adc_seq_pkg::MODE_FIX_SINGLE, adc_seq_pkg::SRC_IMM, 4'h5));
    wait_on(1'b0);
    chk("bnd off", 32'h0, 32'(bnd_irq));
    stop();
  endtask : t_bound
  task t_pdown();
    wr(adc_seq_pkg::CTRL_ADDR, ctl(adc_seq_pkg::MODE_FIX_SINGLE, adc_seq_pkg::SRC_IMM, 4'h1));
    repeat (10) @(posedge aclk);
    pwr_down <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("power en", 32'h0, 32'(adc_power_en));
    pwr_down <= 1'b0;
    repeat (80) @(posedge aclk);
    chk("aborted", 32'h0, 32'(conv_irq));
    stop();
  endtask : t_pdown
  task test_done();
    if (failures == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  // Main sequence: reset for four cycles, then each scenario in turn
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_fix();
    t_dual();
    t_scan();
    t_bound();
    t_pdown();
    test_done();
  end
  // Watchdog well beyond the thousand or so cycles the scenarios need
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    test_done();
  end
endmodule : sar_adc_sequencer_tb
